/* File: hdl/mpc_defines.svh */
/*
  offsets, field positions, reset values and timing counts
  assumes a 100 MHz core clock
*/
`ifndef MPC_DEFINES_SVH
`define MPC_DEFINES_SVH
`define MPC_NPIN 12
`define MPC_PROG_BASE 12'h0400
`define MPC_PROG_DEPTH 512
`define MPC_ADR_GPIO 12'h0808
`define MPC_SLD_BASE 12'h0810
`define MPC_SLA_BASE 12'h0815
`define MPC_NSLOT 5
`define MPC_ADR_CAP0 12'h081A
`define MPC_ADR_CAP1 12'h081B
`define MPC_ADR_CORE 12'h081C
`define MPC_ADR_RAMCFG 12'h081E
`define MPC_ADR_SERIN 12'h081F
`define MPC_ADR_PFLO 12'h0820
`define MPC_ADR_PFHI 12'h0821
`define MPC_ADR_AFLT 12'h0822
`define MPC_ADR_AEN 12'h0824
`define MPC_CORE_GPIOWR 7
`define MPC_CORE_DEB_LSB 12
`define MPC_AEN_BIT 15
`define MPC_AFLT_LSB 8
`define MPC_FLT_HYS4 2'b00
`define MPC_FLT_HYS5 2'b01
`define MPC_FLT_NOLPF 2'b11
`define MPC_HYS4_STEP 13'h0010
`define MPC_HYS5_STEP 13'h0020
`define MPC_FN_DEB 3'h0
`define MPC_FN_OUT 3'h2
`define MPC_FN_OC 3'h3
`define MPC_FN_SER 3'h4
`define MPC_FN_AUX 4'hF
`define MPC_AUX_PIN0 9
`define MPC_AUX_PIN1 2
`define MPC_AUX_PIN2 3
`define MPC_AUX_PIN3 8
`define MPC_SER_OUT_FIRST 6
`define MPC_CLK_MHZ 100
`define MPC_DEB00_MS 20
`define MPC_DEB01_MS 40
`define MPC_DEB10_MS 10
`define MPC_DEB11_MS 5
`define MPC_MS_TO_CYC(ms) ((ms) * 1000 * `MPC_CLK_MHZ)
`define MPC_RST_16 16'h0000
`define MPC_RST_24 24'h00_0000
`endif

/* File: hdl/mpc_pkg.sv */
/*
  types shared by the pin control block
  assumes mpc_defines.svh for numbers
*/
package mpc_pkg;
  // one byte from the control port phy
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mpc_byte_t;
  // one converter sample set, once per fs
  typedef struct packed {
    logic strobe;
    logic [3:0][7:0] sample;
  } mpc_aux_t;
  // four core registers offered to capture
  typedef logic [3:0][23:0] mpc_cap_src_t;
  // control port frame phase
  typedef enum logic [2:0] {
    PH_IDLE, PH_ADRH, PH_ADRL, PH_WDATA, PH_RDATA, PH_SKIP
  } mpc_phase_t;
endpackage

/* File: hdl/mpc_pin_cell.sv */
/*
  one multipurpose pin: sync, debounce, function decode
  assumes padIn is asynchronous, all else on clk
*/
`timescale 1ns/1ps
`include "mpc_defines.svh"
module mpc_pin_cell
  import mpc_pkg::*;
#(
  parameter bit SER_OUT = 1'b0,
  parameter bit AUX_OK = 1'b0,
  parameter int DEB_W = 22
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] fnCode,
  input wire logic [DEB_W-1:0] debCycles,
  input wire logic padIn,
  input wire logic gpioBit,
  input wire logic serOut,
  output logic padOut,
  output logic padOe,
  output logic levelIn,
  output logic isInput,
  output logic isDrive,
  output logic serIn,
  output logic auxEn
);
  logic syncA_q, syncB_q; // two-stage pin sync
  logic stable_q, stable_d; // debounced level
  logic [DEB_W-1:0] cnt_q, cnt_d; // hold timer
  logic inv, rsv;
  logic [2:0] fn;

  // decode the code
  always_comb begin
    fn = fnCode[2:0];
    inv = fnCode[3];
    rsv = (fn > `MPC_FN_SER) && !(fnCode == `MPC_FN_AUX && AUX_OK);
    isInput = !rsv && (fn[2:1] == 2'b00);
    isDrive = (fn == `MPC_FN_OUT) || (fn == `MPC_FN_OC);
    auxEn = (fnCode == `MPC_FN_AUX) && AUX_OK;
    levelIn = ((fn == `MPC_FN_DEB) ? stable_q : syncB_q) ^ inv;
    padOut = 1'b0;
    padOe = 1'b0; // reserved and inputs float
    serIn = 1'b0;
    if (fn == `MPC_FN_OUT) begin
      padOe = 1'b1;
      padOut = gpioBit ^ inv;
    end else if (fn == `MPC_FN_OC) begin
      padOe = !(gpioBit ^ inv);
    end else if (fn == `MPC_FN_SER && SER_OUT) begin
      padOe = 1'b1;
      padOut = serOut ^ inv;
    end else if (fn == `MPC_FN_SER) begin
      serIn = syncB_q ^ inv;
    end
  end

  // debounce: accept only after a full quiet interval
  always_comb begin
    stable_d = stable_q;
    cnt_d = '0;
    if (syncB_q != stable_q) begin
      if (cnt_q >= debCycles - DEB_W'(1)) begin
        stable_d = syncB_q;
      end else begin
        cnt_d = cnt_q + DEB_W'(1);
      end
    end
  end

  // registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
      stable_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      syncA_q <= padIn;
      syncB_q <= syncA_q;
      stable_q <= stable_d;
      cnt_q <= cnt_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_OUT_INV: assert property (
    fnCode == 4'hA |-> padOe && (padOut == !gpioBit))
    else $error("inverted gpio output wrong");
  AST_OC: assert property (
    fnCode == 4'h3 |-> !padOut && (padOe == !gpioBit))
    else $error("open collector drive wrong");
  AST_RSV: assert property (
    (fnCode == 4'h5 || fnCode == 4'hE) |-> !padOe && !serIn && !isInput)
    else $error("reserved code has effect");
  AST_DEB: assert property (
    $changed(stable_q) |-> $past(cnt_q) >= $past(debCycles) - DEB_W'(1))
    else $error("debounce accepted too early");
endmodule

/* File: hdl/mpc_pin_control.sv */
/*
  multipurpose pin control, gpio, capture, safeload slots,
  program memory fill and aux converter filtering behind a
  byte-oriented control port.
  assumes a phy that delivers bytes with a frame level and
  asks for read bytes with rdNext; one clock, async reset.
*/
`timescale 1ns/1ps
`include "mpc_defines.svh"
module mpc_pin_control
  import mpc_pkg::*;
#(
  parameter logic [6:0] DEV_ADR = 7'h3A, // arbitrary value
  parameter int DEB_W = 22,
  parameter int DEB00_CYC = `MPC_MS_TO_CYC(`MPC_DEB00_MS),
  parameter int DEB01_CYC = `MPC_MS_TO_CYC(`MPC_DEB01_MS),
  parameter int DEB10_CYC = `MPC_MS_TO_CYC(`MPC_DEB10_MS),
  parameter int DEB11_CYC = `MPC_MS_TO_CYC(`MPC_DEB11_MS),
  parameter int PROG_DEPTH = `MPC_PROG_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ctlFrame,
  input wire mpc_byte_t ctlByte,
  input wire logic rdNext,
  output logic [7:0] rdByte,
  input wire logic [11:0] mpPadIn,
  output logic [11:0] mpPadOut,
  output logic [11:0] mpPadOe,
  input wire logic [11:0] serDataOut,
  output logic [11:0] serDataIn,
  input wire logic [11:0] coreGpioOut,
  input wire logic [11:0] coreGpioWe,
  output logic [11:0] gpioLevels,
  input wire logic [10:0] progCounter,
  input wire mpc_cap_src_t capSrc,
  input wire logic [8:0] coreProgAdr,
  output logic [39:0] coreProgWord,
  input wire mpc_aux_t aux,
  output logic [3:0][7:0] auxResult,
  output logic [15:0] coreCtrl,
  output logic [7:0] ramCfg,
  output logic [7:0] serInCfg,
  input wire logic slTake,
  output logic [4:0][9:0] slAdr,
  output logic [4:0][27:0] slData,
  output logic [4:0] slDirty
);
  // frame parser state
  mpc_phase_t phase_q, phase_d;
  logic rd_q, rd_d; // read frame
  logic [11:0] adr_q, adr_d; // current location
  logic [31:0] wbuf_q, wbuf_d; // collected data bytes
  logic [2:0] wcnt_q, wcnt_d; // bytes collected
  logic [39:0] rdSh_q, rdSh_d; // outgoing bytes, MSB at top
  logic [2:0] rdCnt_q, rdCnt_d; // bytes sent
  logic [7:0] rdByte_q, rdByte_d;
  logic wrEn, rdLoad, progWe;
  logic [39:0] word, rdVal;
  logic [11:0] rdAdr;
  // register file
  logic [15:0] core_q, core_d;
  logic [1:0][5:0][3:0] pfn_q, pfn_d; // pin codes
  logic [15:0] aflt_q, aflt_d;
  logic [15:0] aen_q, aen_d;
  logic [7:0] ramCfg_q, ramCfg_d;
  logic [7:0] serIn_q, serIn_d;
  logic [11:0] gpio_q, gpio_d;
  logic [1:0][10:0] trap_q, trap_d;
  logic [1:0][1:0] sel_q, sel_d;
  logic [1:0][23:0] cap_q, cap_d;
  logic [4:0][9:0] slA_q, slA_d;
  logic [4:0][27:0] slD_q, slD_d;
  logic [4:0] dirty_q, dirty_d;
  // aux converter path
  logic [3:0][11:0] lp_q, lp_d; // low-pass state
  logic [3:0][11:0] hy_q, hy_d; // hysteresis output
  logic [3:0][7:0] res_q, res_d;
  // program memory
  logic [39:0] progMem [PROG_DEPTH];
  logic [39:0] progWord_q;
  // per-pin wires
  logic [11:0][3:0] pinFn;
  logic [11:0] level, isIn, isDrv, auxPin;
  logic [DEB_W-1:0] debCycles;

  // location inside program memory
  function automatic logic isProg(input logic [11:0] a);
    return a >= `MPC_PROG_BASE && a < `MPC_PROG_BASE + 12'(PROG_DEPTH);
  endfunction

  // safeload slot window, data or address
  function automatic logic inSlot(input logic [11:0] a, input logic [11:0] b);
    return a >= b && a < b + 12'(`MPC_NSLOT);
  endfunction

  // data bytes expected after the header
  function automatic logic [2:0] dataLen(input logic [11:0] a, input logic r);
    if (isProg(a)) return 3'd5;
    if (inSlot(a, `MPC_SLD_BASE)) return 3'd5;
    if (inSlot(a, `MPC_SLA_BASE)) return 3'd2;
    if (a == `MPC_ADR_CAP0 || a == `MPC_ADR_CAP1) return r ? 3'd3 : 3'd2;
    if (a == `MPC_ADR_PFLO || a == `MPC_ADR_PFHI) return 3'd3;
    if (a == `MPC_ADR_RAMCFG || a == `MPC_ADR_SERIN) return 3'd1;
    return 3'd2;
  endfunction

  assign pinFn = pfn_q;
  assign rdAdr = (phase_q == PH_ADRL) ? {adr_q[11:8], ctlByte.data} : adr_q + 12'd1;
  assign word = {wbuf_q, ctlByte.data};

  // debounce interval from core control
  always_comb begin
    unique case (core_q[`MPC_CORE_DEB_LSB+:2])
      2'b00: debCycles = DEB_W'(DEB00_CYC);
      2'b01: debCycles = DEB_W'(DEB01_CYC);
      2'b10: debCycles = DEB_W'(DEB10_CYC);
      2'b11: debCycles = DEB_W'(DEB11_CYC);
    endcase
  end

  // twelve independent pin cells
  for (genvar i = 0; i < `MPC_NPIN; i++) begin : g_pin
    mpc_pin_cell #(
      .SER_OUT(i >= `MPC_SER_OUT_FIRST),
      .AUX_OK(i == `MPC_AUX_PIN0 || i == `MPC_AUX_PIN1 ||
              i == `MPC_AUX_PIN2 || i == `MPC_AUX_PIN3),
      .DEB_W(DEB_W)
    ) u_cell (
      .clk(clk),
      .resetn(resetn),
      .fnCode(pinFn[i]),
      .debCycles(debCycles),
      .padIn(mpPadIn[i]),
      .gpioBit(gpio_q[i]),
      .serOut(serDataOut[i]),
      .padOut(mpPadOut[i]),
      .padOe(mpPadOe[i]),
      .levelIn(level[i]),
      .isInput(isIn[i]),
      .isDrive(isDrv[i]),
      .serIn(serDataIn[i]),
      .auxEn(auxPin[i])
    );
  end

  // read value of a location, right aligned
  always_comb begin
    rdVal = '0;
    if (isProg(rdAdr)) begin
      rdVal = progMem[9'(rdAdr - `MPC_PROG_BASE)];
    end else if (inSlot(rdAdr, `MPC_SLD_BASE)) begin
      rdVal = 40'(slD_q[3'(rdAdr - `MPC_SLD_BASE)]);
    end else if (inSlot(rdAdr, `MPC_SLA_BASE)) begin
      rdVal = 40'(slA_q[3'(rdAdr - `MPC_SLA_BASE)]);
    end else begin
      case (rdAdr)
        `MPC_ADR_GPIO: rdVal = 40'(gpio_q);
        `MPC_ADR_CAP0: rdVal = 40'(cap_q[0]);
        `MPC_ADR_CAP1: rdVal = 40'(cap_q[1]);
        `MPC_ADR_CORE: rdVal = 40'(core_q);
        `MPC_ADR_RAMCFG: rdVal = 40'(ramCfg_q);
        `MPC_ADR_SERIN: rdVal = 40'(serIn_q);
        `MPC_ADR_PFLO: rdVal = 40'(pfn_q[0]);
        `MPC_ADR_PFHI: rdVal = 40'(pfn_q[1]);
        `MPC_ADR_AFLT: rdVal = 40'(aflt_q);
        `MPC_ADR_AEN: rdVal = 40'(aen_q);
        default: rdVal = '0; // unmapped reads zero
      endcase
    end
  end

  // frame parser: header, then data bytes in or out
  always_comb begin
    phase_d = phase_q;
    rd_d = rd_q;
    adr_d = adr_q;
    wbuf_d = wbuf_q;
    wcnt_d = wcnt_q;
    rdSh_d = rdSh_q;
    rdCnt_d = rdCnt_q;
    wrEn = 1'b0;
    rdLoad = 1'b0;
    if (!ctlFrame) begin
      phase_d = PH_IDLE; // frame end drops partial data
    end else if (ctlByte.valid) begin
      unique case (phase_q)
        PH_IDLE: begin
          rd_d = ctlByte.data[0];
          phase_d = (ctlByte.data[7:1] == DEV_ADR) ? PH_ADRH : PH_SKIP;
        end
        PH_ADRH: begin
          adr_d = {ctlByte.data[3:0], 8'h00};
          phase_d = PH_ADRL;
        end
        PH_ADRL: begin
          adr_d = rdAdr;
          wcnt_d = '0;
          rdLoad = rd_q;
          phase_d = rd_q ? PH_RDATA : PH_WDATA;
        end
        PH_WDATA: begin
          if (wcnt_q + 3'd1 == dataLen(adr_q, 1'b0)) begin
            wrEn = 1'b1;
            adr_d = adr_q + 12'd1;
            wcnt_d = '0;
          end else begin
            wbuf_d = word[31:0];
            wcnt_d = wcnt_q + 3'd1;
          end
        end
        PH_RDATA, PH_SKIP: begin
          phase_d = phase_q; // bytes ignored
        end
      endcase
    end
    if (ctlFrame && phase_q == PH_RDATA && rdNext) begin
      if (rdCnt_q + 3'd1 == dataLen(adr_q, 1'b1)) begin
        adr_d = rdAdr;
        rdLoad = 1'b1;
      end else begin
        rdSh_d = {rdSh_q[31:0], 8'h00};
        rdCnt_d = rdCnt_q + 3'd1;
      end
    end
    if (rdLoad) begin
      rdSh_d = rdVal << (6'd8 * 6'(3'd5 - dataLen(rdAdr, 1'b1)));
      rdCnt_d = '0;
    end
    rdByte_d = rdSh_d[39:32];
  end
  assign progWe = wrEn && isProg(adr_q);

  // register file, gpio, capture and safeload
  always_comb begin
    core_d = core_q;
    pfn_d = pfn_q;
    aflt_d = aflt_q;
    aen_d = aen_q;
    ramCfg_d = ramCfg_q;
    serIn_d = serIn_q;
    trap_d = trap_q;
    sel_d = sel_q;
    slA_d = slA_q;
    slD_d = slD_q;
    dirty_d = dirty_q & ~{5{slTake}};
    for (int i = 0; i < `MPC_NPIN; i++) begin
      gpio_d[i] = gpio_q[i];
      if (!core_q[`MPC_CORE_GPIOWR] && isIn[i]) begin
        gpio_d[i] = level[i];
      end else if (isDrv[i] && coreGpioWe[i]) begin
        gpio_d[i] = coreGpioOut[i];
      end
    end
    for (int k = 0; k < 2; k++) begin
      cap_d[k] = cap_q[k];
      if (progCounter == trap_q[k]) begin
        cap_d[k] = capSrc[sel_q[k]];
      end
    end
    if (wrEn) begin
      if (inSlot(adr_q, `MPC_SLA_BASE)) begin
        slA_d[3'(adr_q - `MPC_SLA_BASE)] = word[9:0];
        dirty_d[3'(adr_q - `MPC_SLA_BASE)] = 1'b1;
      end else if (inSlot(adr_q, `MPC_SLD_BASE)) begin
        slD_d[3'(adr_q - `MPC_SLD_BASE)] = word[27:0];
        dirty_d[3'(adr_q - `MPC_SLD_BASE)] = 1'b1;
      end
      case (adr_q)
        `MPC_ADR_GPIO: begin
          if (core_q[`MPC_CORE_GPIOWR]) begin
            gpio_d = word[11:0];
          end
        end
        `MPC_ADR_CAP0, `MPC_ADR_CAP1: begin
          trap_d[adr_q[0]] = word[12:2];
          sel_d[adr_q[0]] = word[1:0];
        end
        `MPC_ADR_CORE: core_d = word[15:0];
        `MPC_ADR_RAMCFG: ramCfg_d = word[7:0];
        `MPC_ADR_SERIN: serIn_d = word[7:0];
        `MPC_ADR_PFLO: pfn_d[0] = word[23:0];
        `MPC_ADR_PFHI: pfn_d[1] = word[23:0];
        `MPC_ADR_AFLT: aflt_d = word[15:0];
        `MPC_ADR_AEN: aen_d = word[15:0];
        default: core_d = core_q; // other locations not held here
      endcase
    end
  end

  // aux converter: low-pass then hysteresis at 12-bit level
  always_comb begin
    logic [1:0] mode;
    logic signed [12:0] diff, step;
    logic [11:0] x12;
    mode = aflt_q[`MPC_AFLT_LSB+:2];
    diff = '0;
    step = '0;
    x12 = '0;
    for (int c = 0; c < 4; c++) begin
      lp_d[c] = lp_q[c];
      hy_d[c] = hy_q[c];
      res_d[c] = res_q[c];
    end
    for (int c = 0; c < 4; c++) begin
      if (!aen_q[`MPC_AEN_BIT] || !auxPin[c == 0 ? `MPC_AUX_PIN0 :
          c == 1 ? `MPC_AUX_PIN1 : c == 2 ? `MPC_AUX_PIN2 : `MPC_AUX_PIN3]) begin
        lp_d[c] = '0;
        hy_d[c] = '0;
        res_d[c] = '0;
      end else if (aux.strobe) begin
        x12 = {aux.sample[c], 4'h0};
        if (mode == `MPC_FLT_NOLPF) begin
          lp_d[c] = x12;
        end else begin
          diff = $signed({1'b0, x12}) - $signed({1'b0, lp_q[c]});
          lp_d[c] = 12'($signed({1'b0, lp_q[c]}) + (diff >>> 2));
        end
        diff = $signed({1'b0, lp_d[c]}) - $signed({1'b0, hy_q[c]});
        step = (mode == `MPC_FLT_HYS4) ? `MPC_HYS4_STEP : `MPC_HYS5_STEP;
        if (mode[1] || diff >= step || -diff >= step) begin
          hy_d[c] = lp_d[c];
        end
        res_d[c] = hy_d[c][11:4];
      end
    end
  end

  // register all state except the program memory array
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= PH_IDLE;
      rd_q <= 1'b0;
      adr_q <= '0;
      wbuf_q <= '0;
      wcnt_q <= '0;
      rdSh_q <= '0;
      rdCnt_q <= '0;
      rdByte_q <= '0;
      core_q <= `MPC_RST_16;
      pfn_q <= {2{`MPC_RST_24}};
      aflt_q <= `MPC_RST_16;
      aen_q <= `MPC_RST_16;
      ramCfg_q <= '0;
      serIn_q <= '0;
      gpio_q <= '0;
      trap_q <= '0;
      sel_q <= '0;
      cap_q <= '0;
      slA_q <= '0;
      slD_q <= '0;
      dirty_q <= '0;
      lp_q <= '0;
      hy_q <= '0;
      res_q <= '0;
      progWord_q <= '0;
    end else begin
      phase_q <= phase_d;
      rd_q <= rd_d;
      adr_q <= adr_d;
      wbuf_q <= wbuf_d;
      wcnt_q <= wcnt_d;
      rdSh_q <= rdSh_d;
      rdCnt_q <= rdCnt_d;
      rdByte_q <= rdByte_d;
      core_q <= core_d;
      pfn_q <= pfn_d;
      aflt_q <= aflt_d;
      aen_q <= aen_d;
      ramCfg_q <= ramCfg_d;
      serIn_q <= serIn_d;
      gpio_q <= gpio_d;
      trap_q <= trap_d;
      sel_q <= sel_d;
      cap_q <= cap_d;
      slA_q <= slA_d;
      slD_q <= slD_d;
      dirty_q <= dirty_d;
      lp_q <= lp_d;
      hy_q <= hy_d;
      res_q <= res_d;
      progWord_q <= progMem[coreProgAdr];
    end
  end

  // program memory array, no reset
  always_ff @(posedge clk) begin
    if (progWe) begin
      progMem[9'(adr_q - `MPC_PROG_BASE)] <= word;
    end
  end

  assign rdByte = rdByte_q;
  assign gpioLevels = gpio_q;
  assign coreProgWord = progWord_q;
  assign auxResult = res_q;
  assign coreCtrl = core_q;
  assign ramCfg = ramCfg_q;
  assign serInCfg = serIn_q;
  assign slAdr = slA_q;
  assign slData = slD_q;
  assign slDirty = dirty_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_CAP: assert property (
    progCounter == trap_q[0] |=> cap_q[0] == $past(capSrc[sel_q[0]]))
    else $error("capture missed trap");
  AST_RD_MSB: assert property (
    (ctlFrame && ctlByte.valid && phase_q == PH_ADRL && rd_q &&
     rdAdr == `MPC_ADR_CAP0) |=> rdByte == $past(cap_q[0][23:16]))
    else $error("capture readback not MSB first");
  AST_BURST: assert property (
    progWe |=> adr_q == $past(adr_q) + 12'd1)
    else $error("burst did not advance");
  AST_GPIO_FOLLOW: assert property (
    !core_q[`MPC_CORE_GPIOWR] && isIn[0] |=> gpio_q[0] == $past(level[0]))
    else $error("gpio did not follow pin");
  AST_AUX_OFF: assert property (
    !aen_q[`MPC_AEN_BIT] |=> auxResult == '0)
    else $error("converter ran while off");
endmodule

/* File: dv/mpc_host_model.sv */
/*
  host side of the byte control port: write and read frames
  assumes callers sit 1 ns after a rising clk edge
*/
`timescale 1ns/1ps
module mpc_host_model
  import mpc_pkg::*;
#(
  parameter logic [6:0] DEV_ADR = 7'h3A // arbitrary value
) (
  input wire logic clk,
  input wire logic [7:0] rdByte,
  output logic ctlFrame,
  output mpc_byte_t ctlByte,
  output logic rdNext
);
  // idle port at time zero
  initial begin
    ctlFrame = 1'b0;
    ctlByte = '0;
    rdNext = 1'b0;
  end
  // one byte per cycle, frame held open
  task automatic put(input logic [7:0] b);
    ctlFrame = 1'b1;
    ctlByte = '{valid: 1'b1, data: b};
    @(posedge clk);
    #1;
  endtask
  // released data line shows the inverse, not the last byte
  task automatic idle();
    ctlByte = '{valid: 1'b0, data: ~ctlByte.data};
  endtask
  // address byte, then location with top nibble zero
  task automatic head(input logic [11:0] loc, input logic rdBit);
    put({DEV_ADR, rdBit});
    put({4'h0, loc[11:8]});
    put(loc[7:0]);
  endtask
  // n data bytes, most significant first
  task automatic wr(input logic [11:0] loc, input int n, input logic [79:0] d);
    head(loc, 1'b0);
    for (int i = n - 1; i >= 0; i--) begin
      put(d[8*i+:8]);
    end
    idle();
    ctlFrame = 1'b0;
    @(posedge clk);
    #1;
  endtask
  // n read bytes, rdNext held while more are wanted
  task automatic rd(input logic [11:0] loc, input int n, output logic [23:0] q);
    head(loc, 1'b1);
    idle();
    @(posedge clk);
    #1;
    q = '0;
    for (int i = 0; i < n; i++) begin
      q = {q[15:0], rdByte};
      if (i < n - 1) begin
        rdNext = 1'b1;
        @(posedge clk);
        #1;
      end
    end
    rdNext = 1'b0;
    ctlFrame = 1'b0;
    @(posedge clk);
    #1;
  endtask
endmodule

/* File: dv/tb_mpc_pin_control.sv */
/*
  self-checking bench for the pin control block
  assumes short debounce counts and DEV_ADR left at default
*/
`timescale 1ns/1ps
module tb_mpc_pin_control
  import mpc_pkg::*;
;
  logic clk, resetn, rdNext, ctlFrame, slTake;
  mpc_byte_t ctlByte;
  mpc_aux_t aux;
  mpc_cap_src_t capSrc;
  logic [7:0] rdByte, ramCfg, serInCfg;
  logic [11:0] mpPadIn, mpPadOut, mpPadOe, serDataOut, serDataIn;
  logic [11:0] coreGpioOut, coreGpioWe, gpioLevels;
  logic [10:0] progCounter;
  logic [8:0] coreProgAdr;
  logic [39:0] coreProgWord;
  logic [3:0][7:0] auxResult;
  logic [15:0] coreCtrl;
  logic [4:0][9:0] slAdr;
  logic [4:0][27:0] slData;
  logic [4:0] slDirty;
  logic [23:0] q;
  int fail_count, checked, n;
  mpc_pin_control #(.DEB00_CYC(8), .DEB01_CYC(16), .DEB10_CYC(4), .DEB11_CYC(2)) i_dut (
    .clk(clk), .resetn(resetn), .ctlFrame(ctlFrame), .ctlByte(ctlByte),
    .rdNext(rdNext), .rdByte(rdByte), .mpPadIn(mpPadIn), .mpPadOut(mpPadOut),
    .mpPadOe(mpPadOe), .serDataOut(serDataOut), .serDataIn(serDataIn),
    .coreGpioOut(coreGpioOut), .coreGpioWe(coreGpioWe), .gpioLevels(gpioLevels),
    .progCounter(progCounter), .capSrc(capSrc), .coreProgAdr(coreProgAdr),
    .coreProgWord(coreProgWord), .aux(aux), .auxResult(auxResult),
    .coreCtrl(coreCtrl), .ramCfg(ramCfg), .serInCfg(serInCfg), .slTake(slTake),
    .slAdr(slAdr), .slData(slData), .slDirty(slDirty));
  mpc_host_model i_host (
    .clk(clk), .rdByte(rdByte), .ctlFrame(ctlFrame), .ctlByte(ctlByte), .rdNext(rdNext));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // one comparison of any result
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // counts, verdict and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // register writes of each width, gpio and pin decode
  task automatic t_regs_pins();
    chk("coreCtrl rst", 0, coreCtrl);
    chk("oe rst", 0, mpPadOe);
    i_host.wr(12'h81C, 2, 16'h0080);
    chk("coreCtrl", 16'h0080, coreCtrl);
    i_host.wr(12'h81E, 1, 8'h5A);
    chk("ramCfg", 8'h5A, ramCfg);
    i_host.wr(12'h81F, 1, 8'hC3);
    chk("serInCfg", 8'hC3, serInCfg);
    i_host.wr(12'h808, 2, 16'h0F0F);
    chk("gpio", 12'hF0F, gpioLevels);
    i_host.wr(12'h820, 3, 24'h41_53A2);
    i_host.wr(12'h821, 3, 24'hC0_0000);
    i_host.rd(12'h820, 3, q);
    chk("pinLowRd", 24'h41_53A2, q);
    chk("oe", 12'h803, mpPadOe);
    chk("out", 2'b01, mpPadOut[1:0]);
    serDataOut = 12'h800;
    mpPadIn[5] = 1'b1;
    tick(4);
    chk("serOut inv", 0, mpPadOut[11]);
    chk("serIn", 1, serDataIn[5]);
    $display("test regs_pins done");
  endtask
  // raw and debounced inputs following the pad
  task automatic t_inputs();
    i_host.wr(12'h81C, 2, 16'h0000);
    // port write refused while bit 7 is clear
    i_host.wr(12'h808, 2, 16'h0000);
    chk("gpioLocked", 1, gpioLevels[1]);
    // core sets an output-configured pin
    coreGpioOut[0] = 1'b0;
    coreGpioWe[0] = 1'b1;
    tick(1);
    coreGpioWe[0] = 1'b0;
    tick(1);
    chk("coreGpio", 0, gpioLevels[0]);
    chk("pad0", 0, mpPadOut[0]);
    mpPadIn[4] = 1'b1;
    mpPadIn[7] = 1'b1;
    tick(3);
    mpPadIn[7] = 1'b0;
    tick(2);
    chk("raw", 1, gpioLevels[4]);
    tick(12);
    chk("glitch", 0, gpioLevels[7]);
    mpPadIn[7] = 1'b1;
    n = 0;
    while (gpioLevels[7] !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    if (n >= 40) begin
      fail_count++;
      print_verdict();
    end
    chk("debWait", 1, n >= 8 && n <= 12);
    $display("test inputs done");
  endtask
  // capture setup, trap and three-byte readback
  task automatic t_capture();
    capSrc = {4{24'h11_1111}};
    capSrc[2] = 24'hAB_CDEF;
    i_host.wr(12'h81A, 2, 16'h048E);
    progCounter = 11'h123;
    tick(1);
    progCounter = 11'h000;
    capSrc[2] = 24'h00_0000;
    i_host.rd(12'h81A, 3, q);
    chk("capture", 24'hAB_CDEF, q);
    $display("test capture done");
  endtask
  // safeload slots and program burst
  task automatic t_load();
    i_host.wr(12'h815, 2, 16'h0301);
    chk("slAdr", 10'h301, slAdr[0]);
    i_host.wr(12'h810, 5, 40'h00_0ABC_DEF1);
    chk("slData", 28'hABC_DEF1, slData[0]);
    chk("dirty", 1, slDirty[0]);
    slTake = 1'b1;
    tick(1);
    slTake = 1'b0;
    tick(1);
    chk("taken", 0, slDirty[0]);
    i_host.wr(12'h400, 10, 80'h01_2345_6789_FE_DCBA_9876);
    coreProgAdr = 9'd1;
    tick(2);
    chk("prog1", 40'hFE_DCBA_9876, coreProgWord);
    coreProgAdr = 9'd0;
    tick(2);
    chk("prog0", 40'h01_2345_6789, coreProgWord);
    $display("test load done");
  endtask
  // converter channel 0 on pin 9, bypass then disable
  task automatic t_aux();
    i_host.wr(12'h821, 3, 24'hC0_F000);
    i_host.wr(12'h822, 2, 16'h0300);
    i_host.wr(12'h824, 2, 16'h8000);
    aux.sample[0] = 8'h5C;
    aux.strobe = 1'b1;
    tick(1);
    aux.strobe = 1'b0;
    tick(1);
    chk("aux0", 8'h5C, auxResult[0]);
    i_host.wr(12'h824, 2, 16'h0000);
    chk("auxOff", 0, auxResult[0]);
    // default filtering: low-pass a quarter step, then 16-step hysteresis
    i_host.wr(12'h822, 2, 16'h0000);
    i_host.wr(12'h824, 2, 16'h8000);
    aux.sample[0] = 8'h80;
    aux.strobe = 1'b1;
    tick(1);
    aux.strobe = 1'b0;
    tick(1);
    chk("auxLpf", 8'h20, auxResult[0]);
    $display("test aux done");
  endtask
  // reset, scenarios, verdict
  initial begin
    resetn = 1'b0;
    fail_count = 0;
    checked = 0;
    slTake = 1'b0;
    aux = '0;
    capSrc = '0;
    mpPadIn = '0;
    serDataOut = '0;
    coreGpioOut = '0;
    coreGpioWe = '0;
    progCounter = '0;
    coreProgAdr = '0;
    tick(12);
    resetn = 1'b1;
    tick(3);
    t_regs_pins();
    t_inputs();
    t_capture();
    t_load();
    t_aux();
    print_verdict();
  end
endmodule
